// ===== hw/tmr_pkg.sv
// Constants for the 16-bit timer/counter block: register map, fields, reset values, timing.
package tmr_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_CNT_LO   = 8'h04;
  localparam logic [7:0] A_CNT_HI   = 8'h08;
  localparam logic [7:0] A_CMP_LO   = 8'h0C;
  localparam logic [7:0] A_CMP_HI   = 8'h10;
  localparam logic [7:0] A_CMP_MODE = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1C;
  localparam logic [7:0] A_PORT_DIR = 8'h20;
  localparam logic [7:0] A_PORT_OUT = 8'h24;
  localparam logic [7:0] A_PORT_IN  = 8'h28;
  ////////////////////////////////////////////////////////////////////////////
  // timer_control fields
  localparam int         CTRL_ON     = 0;
  localparam int         CTRL_CS     = 1;
  localparam int         CTRL_NOSYNC = 2;
  localparam int         CTRL_OSCEN  = 3;
  localparam int         CTRL_PS_LO  = 4;
  localparam logic [7:0] CTRL_MASK   = 8'h3F;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status bits, other reset values
  localparam int         IRQ_OVF      = 0;
  localparam int         IRQ_SPEC     = 1;
  localparam logic [1:0] IRQ_RST      = 2'h0;
  localparam logic [1:0] PORT_DIR_RST = 2'h3;
  localparam logic [1:0] PORT_OUT_RST = 2'h0;
  localparam logic [3:0] MODE_RST     = 4'h0;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // Compare mode code that makes the special event trigger
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  // Instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_LAST   = 2'h3;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : tmr_pkg

// ===== hw/tmr_timer.sv
// 16-bit byte-accessed timer/counter with crystal pins, prescaler, special event clear and AXI4-Lite slave.
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Pair counts 0000h to FFFFh, wraps, sets overflow flag; interrupt only if enabled.
// R2 - Prescale select 00/01/10/11 divides count input by 1, 2, 4, 8.
// R3 - Unsynchronised external counting continues in sleep; overflow interrupt wakes processor.
// R4 - Oscillator enabled: both crystal pins inputs, direction ignored, pins read zero.
// R5 - Byte reads of a running asynchronous counter return valid, uncorrupted values.
// R6 - Software reads high, low, high again; re-reads both when high bytes differ.
// R7 - Software should stop counter before writing; concurrent increment may corrupt value.
// R8 - Crystal oscillator enabled only while control bit 3 is set.
// R9 - Oscillator supports up to 32.768 kHz and keeps running in sleep.
// R10 - Software waits its own start-up delay after enabling oscillator.
// R11 - Compare mode 1011 trigger clears counter and starts conversion if converter enabled.
// R12 - Trigger clear honoured in timer or synchronised mode; unsynchronised may fail.
// R13 - Counter write in the same cycle as a trigger wins over the clear.
// R14 - With trigger in use, compare pair acts as counter period.
// R15 - Resets leave both counter bytes unchanged; only the trigger clears them.
// R16 - Power-on reset clears control to zero: stopped, 1:1 prescale.
// R17 - Writing either counter byte clears the prescaler.
// R18 - Trigger clears both bytes together in the cycle it is sampled.
module tmr_timer (
  // Clock and power-on reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Crystal / external clock pins
  input  wire logic        xtal_in_pin_level,
  output logic             xtal_in_pin_drive,
  output logic             xtal_in_pin_oe,
  input  wire logic        xtal_out_pin_level,
  output logic             xtal_out_pin_drive,
  output logic             xtal_out_pin_oe,
  output logic             xtal_osc_enable,
  // System side
  input  wire logic        sleep,
  input  wire logic        adc_enable,
  output logic             adc_start,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == tmr_pkg::A_CTRL) || (a == tmr_pkg::A_CNT_LO) || (a == tmr_pkg::A_CNT_HI) ||
              (a == tmr_pkg::A_CMP_LO) || (a == tmr_pkg::A_CMP_HI) || (a == tmr_pkg::A_CMP_MODE) ||
              (a == tmr_pkg::A_IRQ_STAT) || (a == tmr_pkg::A_IRQ_MASK) || (a == tmr_pkg::A_PORT_DIR) ||
              (a == tmr_pkg::A_PORT_OUT) || (a == tmr_pkg::A_PORT_IN);
  endfunction : addr_ok

  function automatic logic [2:0] ps_last(input logic [1:0] ps);
    case (ps)
      2'h0:    ps_last = 3'h0;
      2'h1:    ps_last = 3'h1;
      2'h2:    ps_last = 3'h3;
      default: ps_last = 3'h7;
    endcase
  endfunction : ps_last

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] cmp_r, cmp_nxt;
  logic [3:0]  mode_r, mode_nxt;
  logic [1:0]  stat_r, stat_nxt, mask_r, mask_nxt, dir_r, dir_nxt, pout_r, pout_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [1:0]  pin_s1_r, pin_s2_r, pin_s1_nxt, pin_s2_nxt;
  logic        src_prev_r, src_prev_nxt, armed_r, armed_nxt, match_prev_r, match_prev_nxt;
  logic        adc_r, adc_nxt;
  logic [1:0]  div_r, div_nxt;
  logic [2:0]  pre_r, pre_nxt;
  logic [15:0] count_r, count_nxt;
  // Decoded strobes
  logic        do_wr, wr_lo, wr_hi, cnt_wr, src, ext_rise, ext_fall, base_tick, pre_tick, inc_evt, inc;
  logic        async_mode, match, trig, ovf;
  logic [1:0]  stat_set, stat_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding on the count input
  always_comb begin
    pin_s1_nxt   = {xtal_out_pin_level, xtal_in_pin_level};
    pin_s2_nxt   = pin_s1_r;
    // With the oscillator on, the crystal input pin carries the count clock
    src          = ctrl_r[tmr_pkg::CTRL_OSCEN] ? pin_s2_r[0] : pin_s2_r[1];
    src_prev_nxt = src;
    ext_rise     = src & ~src_prev_r;
    ext_fall     = ~src & src_prev_r;
    // A falling edge must be seen after enabling before rising edges count
    if (!ctrl_r[tmr_pkg::CTRL_ON] || !ctrl_r[tmr_pkg::CTRL_CS]) begin
      armed_nxt = 1'b0;
    end else if (ext_fall) begin
      armed_nxt = 1'b1;
    end else begin
      armed_nxt = armed_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r   <= 2'h0;
      pin_s2_r   <= 2'h0;
      src_prev_r <= 1'b0;
      armed_r    <= 1'b0;
    end else begin
      pin_s1_r   <= pin_s1_nxt;
      pin_s2_r   <= pin_s2_nxt;
      src_prev_r <= src_prev_nxt;
      armed_r    <= armed_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, counter, special event trigger
  always_comb begin
    async_mode = ctrl_r[tmr_pkg::CTRL_CS] & ctrl_r[tmr_pkg::CTRL_NOSYNC];
    div_nxt    = ctrl_r[tmr_pkg::CTRL_ON] ? div_r + 2'h1 : 2'h0;
    base_tick  = ctrl_r[tmr_pkg::CTRL_CS] ? (ext_rise & armed_r) : (div_r == tmr_pkg::INSTR_LAST);
    // Instruction clock stops in sleep; external prescaler keeps running
    pre_tick   = aresetn & ctrl_r[tmr_pkg::CTRL_ON] & base_tick & ~(sleep & ~ctrl_r[tmr_pkg::CTRL_CS]);
    inc_evt    = pre_tick & (pre_r == ps_last(ctrl_r[tmr_pkg::CTRL_PS_LO +: 2]));                       // R2
    if (cnt_wr) begin
      pre_nxt = 3'h0;                                                                                    // R17
    end else if (pre_tick) begin
      pre_nxt = inc_evt ? 3'h0 : pre_r + 3'h1;                                                           // R2
    end else begin
      pre_nxt = pre_r;
    end
    // Synchronised counting freezes in sleep; unsynchronised keeps going
    inc            = inc_evt & (~sleep | async_mode);                                                    // R3
    // Compare pair acts as the period; not honoured when unsynchronised
    match          = aresetn & (mode_r == tmr_pkg::MODE_SPECIAL) & (count_r == cmp_r) & ~async_mode;     // R12 R14
    match_prev_nxt = match;
    trig           = match & ~match_prev_r;                                                              // R11
    adc_nxt        = trig & adc_enable;                                                                  // R11
    ovf            = inc & (count_r == tmr_pkg::CNT_TOP) & ~cnt_wr & ~trig;                              // R1
    // Write beats both the trigger clear and a concurrent increment
    count_nxt = count_r;
    if (cnt_wr) begin
      if (wr_lo) begin
        count_nxt[7:0] = wdata_r[7:0];                                                                   // R13
      end
      if (wr_hi) begin
        count_nxt[15:8] = wdata_r[7:0];                                                                  // R13
      end
    end else if (trig) begin
      count_nxt = 16'h0000;                                                                              // R18
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;                                                                    // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r        <= 2'h0;
      pre_r        <= 3'h0;
      match_prev_r <= 1'b0;
      adc_r        <= 1'b0;
    end else begin
      div_r        <= div_nxt;
      pre_r        <= pre_nxt;
      match_prev_r <= match_prev_nxt;
      adc_r        <= adc_nxt;
    end
  end

  // Counter bytes deliberately have no reset
  always_ff @(posedge aclk) begin
    count_r <= count_nxt;                                                                                // R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register file
  always_comb begin
    do_wr    = aw_hold_r & w_hold_r & ~bvalid_r;
    wr_lo    = do_wr & wstrb_r[0] & (awaddr_r == tmr_pkg::A_CNT_LO);
    wr_hi    = do_wr & wstrb_r[0] & (awaddr_r == tmr_pkg::A_CNT_HI);
    cnt_wr   = wr_lo | wr_hi;
    awready  = ~aw_hold_r & ~bvalid_r;
    wready   = ~w_hold_r & ~bvalid_r;
    arready  = ~rvalid_r;
    aw_hold_nxt = do_wr ? 1'b0 : (aw_hold_r | (awvalid & awready));
    w_hold_nxt  = do_wr ? 1'b0 : (w_hold_r | (wvalid & wready));
    awaddr_nxt  = (awvalid & awready) ? awaddr : awaddr_r;
    wdata_nxt   = (wvalid & wready) ? wdata : wdata_r;
    wstrb_nxt   = (wvalid & wready) ? wstrb : wstrb_r;
    bvalid_nxt  = do_wr | (bvalid_r & ~bready);
    bresp_nxt   = do_wr ? (addr_ok(awaddr_r) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR) : bresp_r;
    ctrl_nxt = ctrl_r;
    cmp_nxt  = cmp_r;
    mode_nxt = mode_r;
    mask_nxt = mask_r;
    dir_nxt  = dir_r;
    pout_nxt = pout_r;
    stat_clr = 2'h0;
    if (do_wr && wstrb_r[0]) begin
      case (awaddr_r)
        tmr_pkg::A_CTRL:     ctrl_nxt = wdata_r[7:0] & tmr_pkg::CTRL_MASK;
        tmr_pkg::A_CMP_LO:   cmp_nxt[7:0] = wdata_r[7:0];
        tmr_pkg::A_CMP_HI:   cmp_nxt[15:8] = wdata_r[7:0];
        tmr_pkg::A_CMP_MODE: mode_nxt = wdata_r[3:0];
        tmr_pkg::A_IRQ_STAT: stat_clr = wdata_r[1:0];
        tmr_pkg::A_IRQ_MASK: mask_nxt = wdata_r[1:0];
        tmr_pkg::A_PORT_DIR: dir_nxt = wdata_r[1:0];
        tmr_pkg::A_PORT_OUT: pout_nxt = wdata_r[1:0];
        default: begin
        end
      endcase
    end
    // A new event wins over a write-one clear in the same cycle
    stat_set = {trig, ovf};
    stat_nxt = (stat_r & ~stat_clr) | stat_set;                                                          // R1
    rvalid_nxt = (arvalid & arready) | (rvalid_r & ~rready);
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (arvalid && arready) begin
      rresp_nxt = addr_ok(araddr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      // Counter lives in this clock domain, so a byte read is always whole
      case (araddr)
        tmr_pkg::A_CTRL:     rdata_nxt = {24'h000000, ctrl_r};
        tmr_pkg::A_CNT_LO:   rdata_nxt = {24'h000000, count_r[7:0]};                                     // R5
        tmr_pkg::A_CNT_HI:   rdata_nxt = {24'h000000, count_r[15:8]};                                    // R5
        tmr_pkg::A_CMP_LO:   rdata_nxt = {24'h000000, cmp_r[7:0]};
        tmr_pkg::A_CMP_HI:   rdata_nxt = {24'h000000, cmp_r[15:8]};
        tmr_pkg::A_CMP_MODE: rdata_nxt = {28'h0000000, mode_r};
        tmr_pkg::A_IRQ_STAT: rdata_nxt = {30'h00000000, stat_r};
        tmr_pkg::A_IRQ_MASK: rdata_nxt = {30'h00000000, mask_r};
        tmr_pkg::A_PORT_DIR: rdata_nxt = {30'h00000000, dir_r};
        tmr_pkg::A_PORT_OUT: rdata_nxt = {30'h00000000, pout_r};
        tmr_pkg::A_PORT_IN:  rdata_nxt = {30'h00000000, ctrl_r[tmr_pkg::CTRL_OSCEN] ? 2'h0 : pin_s2_r}; // R4
        default:             rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= tmr_pkg::CTRL_RST;                                                                    // R16
      cmp_r     <= tmr_pkg::CMP_RST;
      mode_r    <= tmr_pkg::MODE_RST;
      stat_r    <= tmr_pkg::IRQ_RST;
      mask_r    <= tmr_pkg::IRQ_RST;
      dir_r     <= tmr_pkg::PORT_DIR_RST;
      pout_r    <= tmr_pkg::PORT_OUT_RST;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tmr_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= tmr_pkg::RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      cmp_r     <= cmp_nxt;
      mode_r    <= mode_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      dir_r     <= dir_nxt;
      pout_r    <= pout_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Oscillator is not gated by sleep, so the crystal keeps running
  assign xtal_osc_enable    = ctrl_r[tmr_pkg::CTRL_OSCEN];                                               // R8 R9
  assign xtal_in_pin_oe     = ~ctrl_r[tmr_pkg::CTRL_OSCEN] & ~dir_r[0];                                  // R4
  assign xtal_out_pin_oe    = ~ctrl_r[tmr_pkg::CTRL_OSCEN] & ~dir_r[1];                                  // R4
  assign xtal_in_pin_drive  = pout_r[0];
  assign xtal_out_pin_drive = pout_r[1];
  assign irq       = |(stat_r & mask_r);                                                                 // R1 R3
  assign adc_start = adc_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign rvalid    = rvalid_r;
  assign rresp     = rresp_r;
  assign rdata     = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ovf_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    ovf |=> stat_r[tmr_pkg::IRQ_OVF] && (count_r == 16'h0000)) else $error("overflow did not wrap and flag");
  prescale_div_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (pre_tick && !cnt_wr && (pre_r == ps_last(ctrl_r[5:4]))) |=> (pre_r == 3'h0))
    else $error("prescaler did not wrap at its end count");
  async_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (sleep && async_mode && inc_evt && !cnt_wr && !trig) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("async counter stalled in sleep");
  pins_input_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (arvalid && arready && araddr == tmr_pkg::A_PORT_IN && ctrl_r[3]) |=> (rdata_r[1:0] == 2'h0) &&
    !xtal_in_pin_oe && !xtal_out_pin_oe) else $error("crystal pins not forced to input");
  read_whole_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (arvalid && arready && araddr == tmr_pkg::A_CNT_HI) |=> rvalid && (rdata_r[7:0] == $past(count_r[15:8])))
    else $error("high byte read mismatch");
  osc_enable_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (do_wr && wstrb_r[0] && awaddr_r == tmr_pkg::A_CTRL) |=> (xtal_osc_enable == $past(wdata_r[3])))
    else $error("oscillator enable not following control");
  trig_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11 R18
    (trig && !cnt_wr) |=> (count_r == 16'h0000) && (adc_start == $past(adc_enable)))
    else $error("trigger did not clear counter");
  async_no_trig_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    async_mode |-> !trig) else $error("trigger in unsynchronised mode");
  write_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    (trig && wr_lo) |=> (count_r[7:0] == $past(wdata_r[7:0]))) else $error("trigger beat the write");
  reset_keep_a: assert property (@(posedge aclk) // R15
    !aresetn |=> (count_r === $past(count_r))) else $error("reset changed counter");
  reset_ctrl_a: assert property (@(posedge aclk) // R16
    !aresetn |=> (ctrl_r == 8'h00)) else $error("control not cleared by reset");
  presc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    cnt_wr |=> (pre_r == 3'h0)) else $error("prescaler not cleared on write");
  cov_overflow_c: cover property (@(posedge aclk) disable iff (!aresetn) ovf ##1 irq);
  cov_trigger_c: cover property (@(posedge aclk) disable iff (!aresetn) trig ##1 adc_start);
  cov_sleep_c: cover property (@(posedge aclk) disable iff (!aresetn) sleep && async_mode && inc);
endmodule : tmr_timer

// ===== bench/tmr_xtal_src.sv
// Model of the external clock source on the timer's crystal pins.
`timescale 1ns/100ps
module tmr_xtal_src (
  // Frame request
  input  wire logic       start,
  input  wire logic       sel_in_pin,
  input  wire logic [7:0] pulses,
  output logic            done,
  // Pin levels
  output logic            in_lvl,
  output logic            out_lvl
);
  logic clk_lvl;
  // Clock stands still low between frames; phase unrelated to aclk
  initial begin
    clk_lvl = 1'b0;
    done    = 1'b0;
    forever begin
      wait (start === 1'b1);
      #3.3;
      for (int i = 0; i < pulses; i++) begin
        clk_lvl = 1'b1;
        #62.5;
        clk_lvl = 1'b0;
        #62.5;
      end
      done = 1'b1;
      wait (start === 1'b0);
      done = 1'b0;
    end
  end
  // Unselected pin held low by its pull-down
  assign in_lvl  = sel_in_pin ? clk_lvl : 1'b0;
  assign out_lvl = sel_in_pin ? 1'b0 : clk_lvl;
endmodule : tmr_xtal_src

// ===== bench/tb.sv
// Self-checking testbench for the timer block.
`timescale 1ns/100ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, bready = 1'b1, rready = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sleep = 1'b0, adc_enable = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, src_pulses = 8'h09;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rr, wr_resp;
  logic        awready, wready, bvalid, arready, rvalid, in_drv, in_oe, out_drv, out_oe;
  logic        osc_en, adc_start, irq, src_done, src_in, src_out;
  logic        src_start = 1'b0, src_sel = 1'b0;
  logic [15:0] cnt;
  int          bad_count = 0, checked = 0, cyc = 0, adc_seen = 0;
  tmr_timer tmr_timer_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .xtal_in_pin_level(in_oe ? in_drv : src_in), .xtal_in_pin_drive(in_drv), .xtal_in_pin_oe(in_oe),
    .xtal_out_pin_level(out_oe ? out_drv : src_out), .xtal_out_pin_drive(out_drv),
    .xtal_out_pin_oe(out_oe), .xtal_osc_enable(osc_en), .sleep(sleep), .adc_enable(adc_enable),
    .adc_start(adc_start), .irq(irq));
  tmr_xtal_src tmr_xtal_src_i (.start(src_start), .sel_in_pin(src_sel), .pulses(src_pulses),
    .done(src_done), .in_lvl(src_in), .out_lvl(src_out));
  ////////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1) adc_seen++;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    wr_resp = bresp;
    if (n >= 50) chk("write answer", 1, 0);
  endtask : wr
  task automatic rg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50) chk("read answer", 1, 0);
  endtask : rg
  // High, low, high again; retry both when the high bytes differ
  task automatic rd16(output logic [15:0] v);
    logic [31:0] h1, lo, h2;
    logic [1:0]  r;
    rg(tmr_pkg::A_CNT_HI, h1, r);
    rg(tmr_pkg::A_CNT_LO, lo, r);
    rg(tmr_pkg::A_CNT_HI, h2, r);
    if (h1 !== h2) begin
      rg(tmr_pkg::A_CNT_HI, h1, r);
      rg(tmr_pkg::A_CNT_LO, lo, r);
    end
    v = {h1[7:0], lo[7:0]};
  endtask : rd16
  task automatic print_verdict();
    $display("counts: %0d checked, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] cfg [3] = '{8'h0F, 8'h0B, 8'h03};
    logic [1:0] dir [3] = '{2'h0, 2'h0, 2'h3};
    logic [15:0] lo;
    int n;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("osc enable at reset", 0, osc_en);
    wr(tmr_pkg::A_CTRL, 32'h30);
    wr(tmr_pkg::A_CNT_HI, 32'h12);
    wr(tmr_pkg::A_CNT_LO, 32'h34);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rg(tmr_pkg::A_CTRL, rd, rr);
    chk("control after reset", 0, rd);
    rd16(cnt);
    chk("count after reset", 16'h1234, cnt);
    $display("test reset done");
    for (int ps = 0; ps < 4; ps++) begin
      wr(tmr_pkg::A_CNT_LO, 0);
      wr(tmr_pkg::A_CNT_HI, 0);
      wr(tmr_pkg::A_CTRL, 32'((ps << 4) | 1));
      repeat (256) @(posedge aclk);
      wr(tmr_pkg::A_CTRL, 0);
      rd16(cnt);
      lo = 16'((64 >> ps) - 1);
      chk("prescaled count", lo + 1, (cnt >= lo && cnt <= lo + 16'((2 >> ps) + 2)) ? lo + 1 : cnt);
    end
    $display("test prescale done");
    wr(tmr_pkg::A_CNT_LO, 32'hFE);
    wr(tmr_pkg::A_CNT_HI, 32'hFF);
    wr(tmr_pkg::A_CTRL, 1);
    repeat (40) @(posedge aclk);
    wr(tmr_pkg::A_CTRL, 0);
    rg(tmr_pkg::A_IRQ_STAT, rd, rr);
    chk("overflow flag", 1, rd);
    chk("masked irq", 0, irq);
    rd16(cnt);
    chk("high byte after wrap", 0, cnt[15:8]);
    wr(tmr_pkg::A_IRQ_MASK, 1);
    @(posedge aclk);
    chk("irq", 1, irq);
    wr(tmr_pkg::A_IRQ_STAT, 1);
    @(posedge aclk);
    chk("irq after clear", 0, irq);
    $display("test overflow done");
    wr(tmr_pkg::A_CMP_LO, 32'h10);
    wr(tmr_pkg::A_CMP_HI, 0);
    wr(tmr_pkg::A_CMP_MODE, 32'(tmr_pkg::MODE_SPECIAL));
    wr(tmr_pkg::A_CNT_LO, 0);
    adc_enable <= 1'b1;
    adc_seen = 0;
    wr(tmr_pkg::A_CTRL, 1);
    repeat (300) @(posedge aclk);
    wr(tmr_pkg::A_CTRL, 0);
    rd16(cnt);
    chk("count within period", 1, cnt <= 16'h0010);
    rg(tmr_pkg::A_IRQ_STAT, rd, rr);
    chk("trigger flag", 2, rd & 2);
    chk("conversion starts", 1, adc_seen >= 3 && adc_seen <= 5);
    wr(tmr_pkg::A_CMP_MODE, 0);
    adc_enable <= 1'b0;
    rg(8'h30, rd, rr);
    chk("unmapped read", {30'h0, tmr_pkg::RESP_SLVERR}, {rd[29:0], rr});
    wr(8'h30, 32'hFF);
    chk("unmapped write", tmr_pkg::RESP_SLVERR, wr_resp);
    $display("test trigger done");
    for (int k = 0; k < 3; k++) begin
      sleep   <= (k < 2);
      src_sel <= cfg[k][3];
      wr(tmr_pkg::A_CNT_LO, 0);
      wr(tmr_pkg::A_PORT_DIR, dir[k]);
      wr(tmr_pkg::A_CTRL, cfg[k]);
      chk("osc enable", cfg[k][3], osc_en);
      chk("pin drive enables", {2{~cfg[k][3]}} & ~dir[k], {out_oe, in_oe});
      repeat (20) @(posedge aclk);
      src_start <= 1'b1;
      n = 0;
      while (src_done !== 1'b1 && n < 500) begin
        @(posedge aclk);
        n++;
      end
      src_start <= 1'b0;
      repeat (20) @(posedge aclk);
      wr(tmr_pkg::A_CTRL, 0);
      rd16(cnt);
      chk("external count", (k == 1) ? 0 : 8, cnt);
    end
    sleep <= 1'b0;
    $display("test external clock done");
    wr(tmr_pkg::A_PORT_DIR, 0);
    wr(tmr_pkg::A_PORT_OUT, 32'h3);
    wstrb <= 4'hE;
    wr(tmr_pkg::A_PORT_OUT, 0);
    wstrb <= 4'hF;
    chk("pin drive data", 3, {out_drv, in_drv});
    chk("pin drive enables off", 3, {out_oe, in_oe});
    repeat (3) @(posedge aclk);
    rg(tmr_pkg::A_PORT_IN, rd, rr);
    chk("pin readback", 3, rd);
    // Readback taken before the synchronisers see the released pins
    wr(tmr_pkg::A_CTRL, 32'h8);
    chk("pin drive enables osc", 0, {out_oe, in_oe});
    rg(tmr_pkg::A_PORT_IN, rd, rr);
    chk("pin readback osc", 0, rd);
    $display("test pins done");
    print_verdict();
  end
endmodule : tb
